// ---- design/dsag_bitrev.sv ----
`timescale 1ns/10ps
module dsag_bitrev
  import dsag_pkg::*;
#(
  parameter int W = ADDR_W
)
(
  input  wire logic [W-1:0] ptr_in,
  input  wire logic [W-1:0] modifier_in,
  output logic      [W-1:0] next_out
);
  logic [W-1:0] rp;
  logic [W-1:0] rm;
  logic [W-1:0] rs;
  genvar g;
  // Reverse-carry add: reverse both, add, reverse back
  for (g = 0; g < W; g++) begin : g_rev
    assign rp[g]           = ptr_in[W-1-g];
    assign rm[g]           = modifier_in[W-1-g];
    assign next_out[W-1-g] = rs[g];
  end
  assign rs = rp + rm;
endmodule

// ---- design/dsag_circ_adj.sv ----
`timescale 1ns/10ps
module dsag_circ_adj
  import dsag_pkg::*;
(
  input  wire logic [15:0] ptr_in,
  input  wire logic        byte_in,
  input  wire logic        inc_in,
  input  wire logic        dec_in,
  input  wire logic        circ_en_in,
  input  wire logic [15:0] circ_start_in,
  input  wire logic [15:0] circ_end_in,
  output logic      [15:0] next_out
);
  logic [15:0] step;
  logic [15:0] start_a;
  logic [15:0] end_a;
  always_comb begin
    step    = byte_in ? STEP_BYTE : STEP_WORD;
    start_a = {circ_start_in[15:1], 1'b0};
    end_a   = {circ_end_in[15:1], 1'b1};
    next_out = ptr_in;
    // Bound checks compare the word address, plus bit 0 on byte access; bounds are forced word-aligned
    if (inc_in) begin
      if (circ_en_in && (ptr_in[15:1] == end_a[15:1]) && (byte_in ? ptr_in[0] : 1'b1)) begin
        next_out = start_a;
      end else begin
        next_out = ptr_in + step;
      end
    end else if (dec_in) begin
      if (circ_en_in && (ptr_in[15:1] == start_a[15:1]) && (byte_in ? !ptr_in[0] : 1'b1)) begin
        next_out = byte_in ? end_a : {end_a[15:1], 1'b0};
      end else begin
        next_out = ptr_in - step;
      end
    end
  end
endmodule

// ---- design/dsag_pkg.sv ----
package dsag_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          NEAR_W        = 13;
  localparam logic [15:0] NEAR_LIMIT    = 16'h2000;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam logic [15:0] DEF_X_LO      = 16'h0800;
  localparam logic [15:0] DEF_X_HI      = 16'h17FF;
  localparam logic [15:0] DEF_Y_LO      = 16'h1800;
  localparam logic [15:0] DEF_Y_HI      = 16'h1FFF;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam int          CIRC_MAX_WORDS = 32768;
  localparam logic [3:0]  STACK_PTR_SEL = 4'hF;

  typedef enum logic [2:0] {
    DSAG_MODE_NONE    = 3'b000,
    DSAG_MODE_POSTINC = 3'b001,
    DSAG_MODE_POSTDEC = 3'b010,
    DSAG_MODE_PREINC  = 3'b011,
    DSAG_MODE_PREDEC  = 3'b100,
    DSAG_MODE_NEAR    = 3'b101,
    DSAG_MODE_BITREV  = 3'b110
  } dsag_mode_type;

  typedef enum logic [1:0] {
    DSAG_PH_IDLE  = 2'b00,
    DSAG_PH_READ  = 2'b01,
    DSAG_PH_WRITE = 2'b10
  } dsag_phase_type;
endpackage

// ---- design/dsag_top.sv ----
// Operation
// - Bottom 8 Kbyte is near space, reached by 13-bit absolute field.
// - X and Y generators produce any address across 64 Kbyte.
// - Unimplemented address: reads give zero, writes dropped, address trap raised.
// - X read and X write generators run independently on separate buses.
// - X read bus returns combined-space data and DSP X operand.
// - Every data write goes only over the X write bus.
// - X read address computed from prefetched instruction, driven at cycle start.
// - X write address computed at cycle start, driven in write phase.
// - Circular mode on X read and write; bit-reverse on X write only.
// - Y generator and bus serve DSP reads only, never writes.
// - Y generator timing matches X read generator.
// - Y supports only DSP post-modify modes plus circular addressing.
// - DSP X pointers use X read unit; Y pointers use Y unit.
// - DSP writes go over X bus to any combined-space address.
// - Word access ignores address bit 0; words stored little-endian.
// - Byte access selects byte by bit 0, placed on low 8 bits.
// - Pointer step is 2 for words, 1 for bytes.
// - Misaligned word access traps; read completes, write is suppressed. A Y read at an odd address only drops bit 0 and does not trap.
// - Any pointer but stack pointer may be circular, auto-wrapped at bounds.
// - One circular buffer in X space, one in Y space.
// - Buffers up to 32K words; checks at word bounds only.
// - DSP X pointer into Y space reads zero; unimplemented address traps.
// - Incrementing pointer at end reloads start; decrementing at start reloads end.
// - Circular start bit 0 fixed at 0, end bit 0 fixed at 1.
`timescale 1ns/10ps
module dsag_top
  import dsag_pkg::*;
#(
  parameter logic [15:0] X_LO = DEF_X_LO,
  parameter logic [15:0] X_HI = DEF_X_HI,
  parameter logic [15:0] Y_LO = DEF_Y_LO,
  parameter logic [15:0] Y_HI = DEF_Y_HI
)
(
  input  wire logic                ref_clk_in,
  input  wire logic                reset_n_in,
  input  wire logic                rd_req_in,
  input  wire logic                rd_byte_in,
  input  wire logic                rd_dsp_in,
  input  wire logic [2:0]          rd_mode_in,
  input  wire logic [3:0]          rd_ptr_sel_in,
  input  wire logic [15:0]         rd_ptr_in,
  input  wire logic [NEAR_W-1:0]   rd_near_in,
  input  wire logic                y_req_in,
  input  wire logic [2:0]          y_mode_in,
  input  wire logic [3:0]          y_ptr_sel_in,
  input  wire logic [15:0]         y_ptr_in,
  input  wire logic                wr_req_in,
  input  wire logic                wr_byte_in,
  input  wire logic [2:0]          wr_mode_in,
  input  wire logic [3:0]          wr_ptr_sel_in,
  input  wire logic [15:0]         wr_ptr_in,
  input  wire logic [NEAR_W-1:0]   wr_near_in,
  input  wire logic [15:0]         wr_data_in,
  input  wire logic [15:0]         bitrev_mod_in,
  input  wire logic                bitrev_en_in,
  input  wire logic                x_circ_en_in,
  input  wire logic [3:0]          x_circ_sel_in,
  input  wire logic [15:0]         x_circ_start_in,
  input  wire logic [15:0]         x_circ_end_in,
  input  wire logic                y_circ_en_in,
  input  wire logic [3:0]          y_circ_sel_in,
  input  wire logic [15:0]         y_circ_start_in,
  input  wire logic [15:0]         y_circ_end_in,
  input  wire logic [15:0]         xmem_rdata_in,
  input  wire logic [15:0]         ymem_rdata_in,
  output logic      [15:0]         xrd_addr_out,
  output logic                     xrd_en_out,
  output logic      [15:0]         yrd_addr_out,
  output logic                     yrd_en_out,
  output logic      [15:0]         xwr_addr_out,
  output logic                     xwr_en_out,
  output logic      [1:0]          xwr_be_out,
  output logic      [15:0]         xwr_data_out,
  output logic      [15:0]         x_rdata_out,
  output logic      [15:0]         y_rdata_out,
  output logic                     rd_ptr_upd_out,
  output logic      [15:0]         rd_ptr_new_out,
  output logic                     y_ptr_upd_out,
  output logic      [15:0]         y_ptr_new_out,
  output logic                     wr_ptr_upd_out,
  output logic      [15:0]         wr_ptr_new_out,
  output logic                     addr_trap_out
);
  typedef struct packed {
    logic [15:0] xrd_addr;
    logic        xrd_en;
    logic        xrd_byte;
    logic        xrd_zero;
    logic        xrd_dsp;
    logic [15:0] yrd_addr;
    logic        yrd_en;
    logic        yrd_zero;
    logic [15:0] xwr_addr;
    logic        xwr_en;
    logic [1:0]  xwr_be;
    logic [15:0] xwr_data;
    logic        rd_upd;
    logic [15:0] rd_new;
    logic        y_upd;
    logic [15:0] y_new;
    logic        wr_upd;
    logic [15:0] wr_new;
    logic        trap;
  } dsag_state_type;

  dsag_state_type st_r;
  dsag_state_type st_nxt;

  logic [15:0] rd_ea;
  logic [15:0] y_ea;
  logic [15:0] wr_ea;
  logic [15:0] rd_mod;
  logic [15:0] y_mod;
  logic [15:0] wr_mod;
  logic [15:0] wr_brev;
  logic        rd_circ;
  logic        y_circ;
  logic        wr_circ;
  logic        rd_impl;
  logic        y_impl;
  logic        wr_impl;
  logic        rd_in_x;
  logic        y_in_y;
  logic        rd_mis;
  logic        wr_mis;
  logic        wr_post;
  logic [15:0] xbyte;

  function automatic logic [15:0] ea_of(input logic [2:0] mode, input logic [15:0] ptr,
                                        input logic [15:0] pre, input logic [NEAR_W-1:0] near);
    case (mode)
      DSAG_MODE_NEAR:   ea_of = {{(ADDR_W-NEAR_W){1'b0}}, near};
      DSAG_MODE_PREINC,
      DSAG_MODE_PREDEC: ea_of = pre;
      default:          ea_of = ptr;
    endcase
  endfunction

  function automatic logic implemented(input logic [15:0] a);
    implemented = (a < NEAR_LIMIT && a < X_LO) || (a >= X_LO && a <= Y_HI);
  endfunction

  // Stack pointer never wraps circularly
  assign rd_circ = x_circ_en_in && (rd_ptr_sel_in == x_circ_sel_in) && (rd_ptr_sel_in != STACK_PTR_SEL);
  assign wr_circ = x_circ_en_in && (wr_ptr_sel_in == x_circ_sel_in) && (wr_ptr_sel_in != STACK_PTR_SEL);
  assign y_circ  = y_circ_en_in && (y_ptr_sel_in == y_circ_sel_in) && (y_ptr_sel_in != STACK_PTR_SEL);

  dsag_circ_adj u_rd_adj (
    .ptr_in        (rd_ptr_in),
    .byte_in       (rd_byte_in),
    .inc_in        (rd_mode_in == DSAG_MODE_POSTINC || rd_mode_in == DSAG_MODE_PREINC),
    .dec_in        (rd_mode_in == DSAG_MODE_POSTDEC || rd_mode_in == DSAG_MODE_PREDEC),
    .circ_en_in    (rd_circ),
    .circ_start_in (x_circ_start_in),
    .circ_end_in   (x_circ_end_in),
    .next_out      (rd_mod)
  );
  dsag_circ_adj u_y_adj (
    .ptr_in        (y_ptr_in),
    .byte_in       (1'b0),
    .inc_in        (y_mode_in == DSAG_MODE_POSTINC),
    .dec_in        (y_mode_in == DSAG_MODE_POSTDEC),
    .circ_en_in    (y_circ),
    .circ_start_in (y_circ_start_in),
    .circ_end_in   (y_circ_end_in),
    .next_out      (y_mod)
  );
  dsag_circ_adj u_wr_adj (
    .ptr_in        (wr_ptr_in),
    .byte_in       (wr_byte_in),
    .inc_in        (wr_mode_in == DSAG_MODE_POSTINC || wr_mode_in == DSAG_MODE_PREINC),
    .dec_in        (wr_mode_in == DSAG_MODE_POSTDEC || wr_mode_in == DSAG_MODE_PREDEC),
    .circ_en_in    (wr_circ),
    .circ_start_in (x_circ_start_in),
    .circ_end_in   (x_circ_end_in),
    .next_out      (wr_mod)
  );
  dsag_bitrev #(.W(ADDR_W)) u_brev (
    .ptr_in      (wr_ptr_in),
    .modifier_in (bitrev_mod_in),
    .next_out    (wr_brev)
  );

  always_comb begin
    rd_ea   = ea_of(rd_mode_in, rd_ptr_in, rd_mod, rd_near_in);
    wr_ea   = ea_of(wr_mode_in, wr_ptr_in, wr_mod, wr_near_in);
    y_ea    = y_ptr_in;
    rd_impl = implemented(rd_ea);
    wr_impl = implemented(wr_ea);
    y_impl  = implemented(y_ea);
    rd_in_x = !(rd_ea >= Y_LO && rd_ea <= Y_HI);
    y_in_y  = y_ea >= Y_LO && y_ea <= Y_HI;
    rd_mis  = !rd_byte_in && rd_ea[0];
    wr_mis  = !wr_byte_in && wr_ea[0];
    wr_post = wr_mode_in == DSAG_MODE_POSTINC || wr_mode_in == DSAG_MODE_POSTDEC;
  end

  // Addresses are formed one cycle ahead and launched from flops at the cycle edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.xrd_en   = rd_req_in;
    st_nxt.xrd_addr = rd_req_in ? {rd_ea[15:1], rd_ea[0] & rd_byte_in} : st_r.xrd_addr;
    st_nxt.xrd_byte = rd_byte_in;
    st_nxt.xrd_dsp  = rd_dsp_in;
    st_nxt.xrd_zero = !rd_impl || (rd_dsp_in && !rd_in_x);
    st_nxt.yrd_en   = y_req_in;
    st_nxt.yrd_addr = y_req_in ? {y_ea[15:1], 1'b0} : st_r.yrd_addr;
    st_nxt.yrd_zero = !y_impl || !y_in_y;
    st_nxt.xwr_en   = wr_req_in && wr_impl && !wr_mis;
    st_nxt.xwr_addr = wr_req_in ? {wr_ea[15:1], wr_ea[0] & wr_byte_in} : st_r.xwr_addr;
    st_nxt.xwr_be   = wr_byte_in ? (wr_ea[0] ? 2'b10 : 2'b01) : 2'b11;
    st_nxt.xwr_data = wr_byte_in ? {wr_data_in[7:0], wr_data_in[7:0]} : wr_data_in;
    st_nxt.rd_upd   = rd_req_in && rd_mode_in != DSAG_MODE_NONE && rd_mode_in != DSAG_MODE_NEAR;
    st_nxt.rd_new   = rd_mod;
    st_nxt.y_upd    = y_req_in && (y_mode_in == DSAG_MODE_POSTINC || y_mode_in == DSAG_MODE_POSTDEC);
    st_nxt.y_new    = y_mod;
    st_nxt.wr_upd   = wr_req_in && (wr_post || wr_mode_in == DSAG_MODE_PREINC || wr_mode_in == DSAG_MODE_PREDEC
                      || (wr_mode_in == DSAG_MODE_BITREV));
    st_nxt.wr_new   = (wr_mode_in == DSAG_MODE_BITREV && bitrev_en_in) ? wr_brev : wr_mod;
    st_nxt.trap     = (rd_req_in && (!rd_impl || rd_mis)) || (y_req_in && !y_impl)
                      || (wr_req_in && (!wr_impl || wr_mis));
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Misaligned word read still completes, only traps
  always_comb begin
    xbyte = st_r.xrd_addr[0] ? {8'h00, xmem_rdata_in[15:8]} : {8'h00, xmem_rdata_in[7:0]};
    x_rdata_out = st_r.xrd_zero ? ZERO_WORD : (st_r.xrd_byte ? xbyte : xmem_rdata_in);
    y_rdata_out = st_r.yrd_zero ? ZERO_WORD : ymem_rdata_in;
  end

  assign xrd_addr_out   = st_r.xrd_addr;
  assign xrd_en_out     = st_r.xrd_en;
  assign yrd_addr_out   = st_r.yrd_addr;
  assign yrd_en_out     = st_r.yrd_en;
  assign xwr_addr_out   = st_r.xwr_addr;
  assign xwr_en_out     = st_r.xwr_en;
  assign xwr_be_out     = st_r.xwr_be;
  assign xwr_data_out   = st_r.xwr_data;
  assign rd_ptr_upd_out = st_r.rd_upd;
  assign rd_ptr_new_out = st_r.rd_new;
  assign y_ptr_upd_out  = st_r.y_upd;
  assign y_ptr_new_out  = st_r.y_new;
  assign wr_ptr_upd_out = st_r.wr_upd;
  assign wr_ptr_new_out = st_r.wr_new;
  assign addr_trap_out  = st_r.trap;
endmodule

// ---- dv/dsag_mem_model.sv ----
`timescale 1ns/10ps
module dsag_mem_model (
  input  wire logic [15:0] xrd_addr_out,
  input  wire logic        xrd_en_out,
  input  wire logic [15:0] yrd_addr_out,
  input  wire logic        yrd_en_out,
  output logic      [15:0] xmem_rdata_in,
  output logic      [15:0] ymem_rdata_in
);
  // Word memories; a deselected bus shows the inverted address so stale data cannot pass
  assign xmem_rdata_in = xrd_en_out ? {xrd_addr_out[15:1], 1'b0} ^ 16'h5A5A : ~xrd_addr_out;
  assign ymem_rdata_in = yrd_en_out ? {yrd_addr_out[15:1], 1'b0} ^ 16'hC3C3 : ~yrd_addr_out;
endmodule

// ---- dv/dsag_props.sv ----
`timescale 1ns/10ps
module dsag_props
  import dsag_pkg::*;
#(
  parameter logic [15:0] Y_HI = DEF_Y_HI
)
(
  input wire logic        ref_clk_in,
  input wire logic        reset_n_in,
  input wire logic        rd_req_in,
  input wire logic        rd_byte_in,
  input wire logic        rd_dsp_in,
  input wire logic [2:0]  rd_mode_in,
  input wire logic [15:0] rd_ptr_in,
  input wire logic        y_req_in,
  input wire logic        wr_req_in,
  input wire logic        wr_byte_in,
  input wire logic [2:0]  wr_mode_in,
  input wire logic [15:0] wr_ptr_in,
  input wire logic        x_circ_en_in,
  input wire logic [15:0] xrd_addr_out,
  input wire logic        xrd_en_out,
  input wire logic        yrd_en_out,
  input wire logic        xwr_en_out,
  input wire logic [15:0] x_rdata_out,
  input wire logic        rd_ptr_upd_out,
  input wire logic [15:0] rd_ptr_new_out,
  input wire logic        addr_trap_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_dsp_req; rd_req_in && rd_dsp_in && y_req_in; endsequence
  sequence s_both_rd; xrd_en_out && yrd_en_out; endsequence
  property p_pair; s_dsp_req |=> s_both_rd; endproperty
  a_pair: assert property (p_pair) else $error("dual read not issued together");
  property p_xrd_idle; !rd_req_in |=> !xrd_en_out; endproperty
  a_xrd_idle: assert property (p_xrd_idle) else $error("x read without request");
  property p_yrd_idle; !y_req_in |=> !yrd_en_out; endproperty
  a_yrd_idle: assert property (p_yrd_idle) else $error("y read without request");
  property p_wr_idle; !wr_req_in |=> !xwr_en_out; endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("write without request");
  property p_word_addr; xrd_en_out && !$past(rd_byte_in) |-> !xrd_addr_out[0]; endproperty
  a_word_addr: assert property (p_word_addr) else $error("word address bit0 set");
  property p_byte_lane; xrd_en_out && $past(rd_byte_in) |-> x_rdata_out[15:8] == 8'h00; endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte read upper lane not zero");
  property p_step;
    rd_req_in && !rd_byte_in && rd_mode_in == 3'h1 && !x_circ_en_in && rd_ptr_in <= Y_HI
      |=> rd_ptr_upd_out && rd_ptr_new_out == $past(rd_ptr_in) + 16'h0002;
  endproperty
  a_step: assert property (p_step) else $error("word post-increment step wrong");
  property p_misal_wr; wr_req_in && !wr_byte_in && wr_mode_in == 3'h0 && wr_ptr_in[0] |=> addr_trap_out && !xwr_en_out;
  endproperty
  a_misal_wr: assert property (p_misal_wr) else $error("misaligned write not suppressed");
  property p_far_wr; wr_req_in && wr_mode_in == 3'h0 && wr_ptr_in > Y_HI |=> addr_trap_out && !xwr_en_out; endproperty
  a_far_wr: assert property (p_far_wr) else $error("unimplemented write not dropped");
  property p_far_rd; rd_req_in && rd_mode_in == 3'h0 && rd_ptr_in > Y_HI |=> addr_trap_out && x_rdata_out == 16'h0000;
  endproperty
  a_far_rd: assert property (p_far_rd) else $error("unimplemented read not zero");
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb;
  logic        ref_clk_in, reset_n_in, rd_req_in, rd_byte_in, rd_dsp_in, y_req_in, wr_req_in, wr_byte_in;
  logic        bitrev_en_in, x_circ_en_in, y_circ_en_in, xrd_en_out, yrd_en_out, xwr_en_out;
  logic        rd_ptr_upd_out, y_ptr_upd_out, wr_ptr_upd_out, addr_trap_out;
  logic [1:0]  xwr_be_out;
  logic [2:0]  rd_mode_in, y_mode_in, wr_mode_in;
  logic [3:0]  rd_ptr_sel_in, y_ptr_sel_in, wr_ptr_sel_in, x_circ_sel_in, y_circ_sel_in;
  logic [12:0] rd_near_in, wr_near_in;
  logic [15:0] rd_ptr_in, y_ptr_in, wr_ptr_in, wr_data_in, bitrev_mod_in, x_circ_start_in, x_circ_end_in;
  logic [15:0] y_circ_start_in, y_circ_end_in, xmem_rdata_in, ymem_rdata_in, xrd_addr_out, yrd_addr_out;
  logic [15:0] xwr_addr_out, xwr_data_out, x_rdata_out, y_rdata_out, rd_ptr_new_out, y_ptr_new_out, wr_ptr_new_out;
  int          fail_count, samples_checked;

  dsag_top i_dut (.*);
  dsag_mem_model i_mem (.*);

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  function automatic logic [15:0] xw(input logic [15:0] a);
    return {a[15:1], 1'b0} ^ 16'h5A5A;
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One request cycle; answers are settled by the following falling edge
  task automatic rd(input logic dsp, byt, input logic [2:0] md, input logic [3:0] sel, input logic [15:0] p,
                    input logic yq, input logic [15:0] yp, input logic [2:0] ym);
    @(posedge ref_clk_in);
    {rd_req_in, rd_dsp_in, rd_byte_in, rd_mode_in, rd_ptr_sel_in, rd_ptr_in} <= {1'b1, dsp, byt, md, sel, p};
    {y_req_in, y_mode_in, y_ptr_sel_in, y_ptr_in} <= {yq, ym, 4'hA, yp};
    @(posedge ref_clk_in);
    {rd_req_in, y_req_in} <= 2'b00;
    @(negedge ref_clk_in);
  endtask

  task automatic wr(input logic byt, input logic [15:0] p, input logic [15:0] d);
    @(posedge ref_clk_in);
    {wr_req_in, wr_byte_in, wr_mode_in, wr_ptr_sel_in, wr_ptr_in, wr_data_in} <= {1'b1, byt, 3'h0, 4'h1, p, d};
    @(posedge ref_clk_in);
    wr_req_in <= 1'b0;
    @(negedge ref_clk_in);
  endtask

  task automatic sc_dual;
    rd(1'b1, 1'b0, 3'h1, 4'h8, 16'h0900, 1'b1, 16'h1900, 3'h1);
    chk({xrd_en_out, yrd_en_out}, 16'h0003);
    chk(xrd_addr_out, 16'h0900);
    chk(yrd_addr_out, 16'h1900);
    chk(x_rdata_out, xw(16'h0900));
    chk(y_rdata_out, 16'h1900 ^ 16'hC3C3);
    chk(rd_ptr_new_out, 16'h0902);
    chk(y_ptr_new_out, 16'h1902);
    chk({rd_ptr_upd_out, y_ptr_upd_out}, 16'h0003);
  endtask

  // Reverse-carry step of 8 from 0x0808 lands on 0x0804
  task automatic sc_brev;
    @(posedge ref_clk_in);
    {wr_req_in, wr_byte_in, wr_mode_in, wr_ptr_in, bitrev_mod_in, bitrev_en_in} <= {1'b1, 1'b0, 3'h6, 16'h0808, 16'h0008, 1'b1};
    @(posedge ref_clk_in);
    {wr_req_in, bitrev_en_in} <= 2'b00;
    @(negedge ref_clk_in);
    chk({wr_ptr_upd_out, xwr_en_out}, 16'h0003);
    chk(wr_ptr_new_out, 16'h0804);
    chk(xwr_addr_out, 16'h0808);
  endtask

  task automatic sc_align;
    rd(1'b0, 1'b1, 3'h1, 4'h1, 16'h0901, 1'b0, 16'h0000, 3'h0);
    chk(x_rdata_out, 16'h0053);
    chk(rd_ptr_new_out, 16'h0902);
    rd(1'b0, 1'b0, 3'h4, 4'h1, 16'h0A00, 1'b0, 16'h0000, 3'h0);
    chk(xrd_addr_out, 16'h09FE);
    rd(1'b0, 1'b0, 3'h0, 4'h1, 16'h0903, 1'b0, 16'h0000, 3'h0);
    chk({xrd_en_out, addr_trap_out}, 16'h0003);
    chk(x_rdata_out, xw(16'h0902));
  endtask

  task automatic sc_write;
    wr(1'b0, 16'h0A00, 16'h1234);
    chk({xwr_en_out, xwr_be_out, addr_trap_out}, 16'h000E);
    chk(xwr_addr_out, 16'h0A00);
    chk(xwr_data_out, 16'h1234);
    wr(1'b1, 16'h0A01, 16'h00AB);
    chk({xwr_en_out, xwr_be_out}, 16'h0006);
    chk(xwr_data_out, 16'hABAB);
    wr(1'b0, 16'h0A01, 16'h5555);
    chk({xwr_en_out, addr_trap_out}, 16'h0001);
    wr(1'b0, 16'h3000, 16'h5555);
    chk({xwr_en_out, addr_trap_out}, 16'h0001);
    wr(1'b0, 16'h1900, 16'h7777);
    chk({xwr_en_out, addr_trap_out}, 16'h0002);
  endtask

  task automatic sc_space;
    rd_near_in <= 13'h1ABC;
    rd(1'b0, 1'b0, 3'h5, 4'h1, 16'h0000, 1'b0, 16'h0000, 3'h0);
    chk(xrd_addr_out, 16'h1ABC);
    chk(x_rdata_out, xw(16'h1ABC));
    rd(1'b1, 1'b0, 3'h0, 4'h8, 16'h1900, 1'b1, 16'h0900, 3'h0);
    chk(x_rdata_out, 16'h0000);
    chk(y_rdata_out, 16'h0000);
    rd(1'b0, 1'b0, 3'h0, 4'h1, 16'h3000, 1'b0, 16'h0000, 3'h0);
    chk({x_rdata_out[0], addr_trap_out}, 16'h0001);
  endtask

  task automatic sc_circ;
    // Y buffer kept word-sized: the Y bus has no byte lanes
    @(posedge ref_clk_in);
    {x_circ_en_in, x_circ_sel_in, x_circ_start_in, x_circ_end_in} <= {1'b1, 4'h8, 16'h0A00, 16'h0A06};
    {y_circ_en_in, y_circ_sel_in, y_circ_start_in, y_circ_end_in} <= {1'b1, 4'hA, 16'h1901, 16'h1907};
    rd(1'b1, 1'b0, 3'h1, 4'h8, 16'h0A06, 1'b1, 16'h1900, 3'h2);
    chk(rd_ptr_new_out, 16'h0A00);
    chk(y_ptr_new_out, 16'h1906);
    x_circ_sel_in <= 4'hF;
    rd(1'b0, 1'b0, 3'h1, 4'hF, 16'h0A06, 1'b0, 16'h0000, 3'h0);
    chk(rd_ptr_new_out, 16'h0A08);
  endtask

  initial begin
    {reset_n_in, rd_req_in, rd_byte_in, rd_dsp_in, y_req_in, wr_req_in, wr_byte_in, bitrev_en_in} = '0;
    {x_circ_en_in, y_circ_en_in, rd_mode_in, y_mode_in, wr_mode_in, rd_ptr_sel_in, y_ptr_sel_in} = '0;
    {wr_ptr_sel_in, x_circ_sel_in, y_circ_sel_in, rd_near_in, wr_near_in, rd_ptr_in, y_ptr_in} = '0;
    {wr_ptr_in, wr_data_in, bitrev_mod_in, x_circ_start_in, x_circ_end_in, y_circ_start_in, y_circ_end_in} = '0;
    fail_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    sc_dual();
    sc_align();
    sc_write();
    sc_space();
    sc_circ();
    sc_brev();
    test_done();
  end

  // Guards against a stalled sequence
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    fail_count++;
    test_done();
  end
endmodule

bind dsag_top dsag_props #(.Y_HI(Y_HI)) i_props (.*);
